// ==== rtl/pdt_regs.svh ====
// timing constants for the power negotiation supervision timers
// Function
// - continuous test mode exits within the continuous test exit limit after GoodCRC.
// - new source holds Source_Capabilities until caps hold time after own PS_RDY ack.
// - new sink accepts Source_Capabilities within consumer ready time after its GoodCRC.
// - report reset signaling sent if physical layer silent past send guard time.
// - after supply reset delay, drop plug supply, pullup, and discharge the bus.
// - unexpected role exchange in modal operation starts hard reset within fault time.
// - reply timer for vendor commands, entry and leave timers for mode commands.
// - reply timer starts on request GoodCRC, stops on response, expiry flags miss.
// - reply timeout recovery depends on which command was sent.
// - responder starts reply within general, entry or leave answer limit.
// - entry timer runs from enter GoodCRC until ACK, NAK or BUSY.
// - leave timer runs from exit GoodCRC until ACK only.
// - entry or leave timer expiry notifies the device policy manager.
// - after BUSY wait at least the retry backoff before repeating the request.
// - plug supply on timer runs from Accept GoodCRC until PS_RDY received.
// - plug supply must be on before PS_RDY is transmitted.
// - initial plug supply provider stops within off limit after PS_RDY.
// - this port never inserts the legacy cable gap before cable packets.
`ifndef PDT_REGS_SVH
`define PDT_REGS_SVH
`define PDT_CLK_PERIOD_NS   4
`define PDT_US_NS           1000
`define PDT_CLK_PER_US      (`PDT_US_NS / `PDT_CLK_PERIOD_NS)
`define PDT_US_PER_MS       1000
`define PDT_TMR_W           8
// cycles from the last counted tick to a registered expiry output
`define PDT_OUT_LAT         2
// limits in milliseconds, picked inside the permitted ranges
`define PDT_CONT_EXIT_MS    50
`define PDT_CAPS_HOLD_MS    22
`define PDT_SINK_READY_MS   10
`define PDT_GUARD_MS        5
`define PDT_SUPPLY_RST_MS   30
`define PDT_ROLE_FAULT_MS   10
`define PDT_REPLY_WAIT_MS   27
`define PDT_ENTRY_WAIT_MS   45
`define PDT_LEAVE_WAIT_MS   45
`define PDT_BACKOFF_MS      52
`define PDT_PLUG_ON_MS      100
`define PDT_ANSWER_MS       15
`define PDT_ENTRY_ANS_MS    25
`define PDT_LEAVE_ANS_MS    25
`endif

// ==== rtl/pdt_pkg.sv ====
// types shared by the supervision timers
package pdt_pkg;
	typedef enum logic [1:0] {PDT_CMD_OTHER, PDT_CMD_ENTER, PDT_CMD_EXIT} pdt_cmd_t;
	typedef enum logic [1:0] {PDT_RSP_ACK, PDT_RSP_NAK, PDT_RSP_BUSY} pdt_rsp_t;
endpackage

// ==== rtl/pdt_timer.sv ====
// tick-driven one-shot timer with a single-cycle expiry pulse
module pdt_timer #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic         clear,
	input  wire logic [W-1:0] limit,
	output logic              running,
	output logic              expired
);
	logic [W-1:0] cnt_q;
	logic         run_q;
	logic         exp_q;
	logic         last;
	logic         kill;

	assign last = run_q && tick && (cnt_q == limit - W'(1));
	assign kill = rst || clear || stop;

	always_ff @(posedge clock) begin
		if (kill) begin
			run_q <= 1'b0;
			cnt_q <= '0;
		end else if (start) begin
			run_q <= 1'b1;
			cnt_q <= '0;
		end else if (last) begin
			run_q <= 1'b0;
		end else if (run_q && tick) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	always_ff @(posedge clock) begin
		exp_q <= !kill && !start && last;
	end

	assign running = run_q;
	assign expired = exp_q;
endmodule

// ==== rtl/pdt_protocol_timers.sv ====
// supervision timers and deadlines of the power negotiation port
`include "pdt_regs.svh"
module pdt_protocol_timers
	import pdt_pkg::*;
#(
	parameter int W          = `PDT_TMR_W,
	parameter int US_PER_MS  = `PDT_US_PER_MS,
	parameter int CONT_EXIT  = `PDT_CONT_EXIT_MS,
	parameter int CAPS_HOLD  = `PDT_CAPS_HOLD_MS,
	parameter int SINK_READY = `PDT_SINK_READY_MS,
	parameter int GUARD      = `PDT_GUARD_MS,
	parameter int SUPPLY_RST = `PDT_SUPPLY_RST_MS,
	parameter int ROLE_FAULT = `PDT_ROLE_FAULT_MS,
	parameter int REPLY_WAIT = `PDT_REPLY_WAIT_MS,
	parameter int ENTRY_WAIT = `PDT_ENTRY_WAIT_MS,
	parameter int LEAVE_WAIT = `PDT_LEAVE_WAIT_MS,
	parameter int BACKOFF    = `PDT_BACKOFF_MS,
	parameter int PLUG_ON    = `PDT_PLUG_ON_MS,
	parameter int ANSWER     = `PDT_ANSWER_MS,
	parameter int ENTRY_ANS  = `PDT_ENTRY_ANS_MS,
	parameter int LEAVE_ANS  = `PDT_LEAVE_ANS_MS
) (
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire logic     cont_test_goodcrc,
	output logic          cont_test_exit,
	input  wire logic     swap_src_goodcrc,
	output logic          caps_send_ok,
	input  wire logic     swap_snk_goodcrc,
	output logic          sink_caps_ready,
	input  wire logic     hr_request,
	input  wire logic     hr_phy_sent,
	input  wire logic     hr_done,
	output logic          hr_sent_report,
	input  wire logic     is_source,
	output logic          pullup_en,
	output logic          bus_discharge,
	input  wire logic     role_xchg_goodcrc,
	output logic          hr_start,
	input  wire logic     vdm_req_acked,
	input  wire pdt_cmd_t vdm_req_cmd,
	input  wire logic     vdm_rsp_rx,
	input  wire pdt_rsp_t vdm_rsp_code,
	output logic          vdm_reply_timeout,
	output pdt_cmd_t      vdm_timeout_cmd,
	output logic          dpm_notify,
	output logic          vdm_retry_ok,
	input  wire logic     vdm_in_req_rx,
	input  wire pdt_cmd_t vdm_in_req_cmd,
	input  wire logic     vdm_in_rsp_start,
	output logic          vdm_answer_late,
	input  wire logic     plug_accept_goodcrc,
	input  wire logic     plug_take_over,
	input  wire logic     plug_ps_rdy_rx,
	input  wire logic     plug_supply_on_req,
	output logic          plug_supply_en,
	output logic          plug_on_timeout,
	output logic          ps_rdy_tx_ok,
	output logic          legacy_gap_en
);
	localparam int CLK_PER_US = `PDT_CLK_PER_US;

	logic [$clog2(CLK_PER_US)-1:0] us_cnt_q;
	logic [$clog2(US_PER_MS)-1:0]  ms_cnt_q;
	logic                          us_tick;
	logic                          ms_tick_q;
	logic                          clr;

	// cycle to microsecond to millisecond tick divider
	assign us_tick = (us_cnt_q == ($clog2(CLK_PER_US))'(CLK_PER_US - 1));
	always_ff @(posedge clock) begin
		if (rst || us_tick) begin
			us_cnt_q <= '0;
		end else begin
			us_cnt_q <= us_cnt_q + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			ms_cnt_q  <= '0;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= 1'b0;
			if (us_tick) begin
				if (ms_cnt_q == ($clog2(US_PER_MS))'(US_PER_MS - 1)) begin
					ms_cnt_q  <= '0;
					ms_tick_q <= 1'b1;
				end else begin
					ms_cnt_q <= ms_cnt_q + 1'b1;
				end
			end
		end
	end

	// hard reset signaling flushes every timer except the guard timer and the supply reset timer it starts
	assign clr = hr_done;

	function automatic logic [W-1:0] lim(input int ms);
		return W'(ms);
	endfunction

	function automatic logic [W-1:0] ans_lim_d(input pdt_cmd_t c);
		case (c)
			PDT_CMD_ENTER: return lim(ENTRY_ANS);
			PDT_CMD_EXIT:  return lim(LEAVE_ANS);
			default:       return lim(ANSWER);
		endcase
	endfunction

	logic bist_exp, hold_run, hold_exp, rdy_exp, guard_run, guard_exp, sup_exp;
	logic fault_exp, reply_exp, entry_exp, leave_exp, busy_run, on_exp, ans_exp;
	logic rsp_any, entry_stop, leave_stop;
	logic [W-1:0] ans_lim_q;

	pdt_timer #(.W(W)) u_bist (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(cont_test_goodcrc), .stop(1'b0), .clear(clr), .limit(lim(CONT_EXIT)),
		.running(), .expired(bist_exp));
	pdt_timer #(.W(W)) u_hold (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(swap_src_goodcrc), .stop(1'b0), .clear(clr), .limit(lim(CAPS_HOLD)),
		.running(hold_run), .expired(hold_exp));
	pdt_timer #(.W(W)) u_rdy (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(swap_snk_goodcrc), .stop(1'b0), .clear(clr), .limit(lim(SINK_READY)),
		.running(), .expired(rdy_exp));
	pdt_timer #(.W(W)) u_guard (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(hr_request), .stop(hr_phy_sent), .clear(1'b0), .limit(lim(GUARD)),
		.running(guard_run), .expired(guard_exp));
	pdt_timer #(.W(W)) u_supply (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(hr_done && is_source), .stop(1'b0), .clear(1'b0),
		.limit(lim(SUPPLY_RST)), .running(), .expired(sup_exp));
	pdt_timer #(.W(W)) u_fault (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(role_xchg_goodcrc), .stop(1'b0), .clear(clr), .limit(lim(ROLE_FAULT)),
		.running(), .expired(fault_exp));

	// vendor command supervision, one timer per command class
	assign rsp_any    = vdm_rsp_rx;
	assign entry_stop = vdm_rsp_rx;
	assign leave_stop = vdm_rsp_rx && (vdm_rsp_code == PDT_RSP_ACK);

	pdt_timer #(.W(W)) u_reply (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(vdm_req_acked && vdm_req_cmd == PDT_CMD_OTHER), .stop(rsp_any),
		.clear(clr), .limit(lim(REPLY_WAIT)), .running(), .expired(reply_exp));
	pdt_timer #(.W(W)) u_entry (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(vdm_req_acked && vdm_req_cmd == PDT_CMD_ENTER), .stop(entry_stop),
		.clear(clr), .limit(lim(ENTRY_WAIT)), .running(), .expired(entry_exp));
	pdt_timer #(.W(W)) u_leave (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(vdm_req_acked && vdm_req_cmd == PDT_CMD_EXIT), .stop(leave_stop),
		.clear(clr), .limit(lim(LEAVE_WAIT)), .running(), .expired(leave_exp));
	pdt_timer #(.W(W)) u_busy (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(vdm_rsp_rx && vdm_rsp_code == PDT_RSP_BUSY), .stop(1'b0),
		.clear(clr), .limit(lim(BACKOFF)), .running(busy_run), .expired());
	pdt_timer #(.W(W)) u_ans (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(vdm_in_req_rx), .stop(vdm_in_rsp_start), .clear(clr),
		.limit(vdm_in_req_rx ? ans_lim_d(vdm_in_req_cmd) : ans_lim_q),
		.running(), .expired(ans_exp));
	pdt_timer #(.W(W)) u_plug_on (.clock(clock), .rst(rst), .tick(ms_tick_q),
		.start(plug_accept_goodcrc), .stop(plug_ps_rdy_rx), .clear(clr),
		.limit(lim(PLUG_ON)), .running(), .expired(on_exp));

	always_ff @(posedge clock) begin
		if (rst) begin
			ans_lim_q <= lim(ANSWER);
		end else if (vdm_in_req_rx) begin
			ans_lim_q <= ans_lim_d(vdm_in_req_cmd);
		end
	end

	// command under supervision, reported with its timeout
	pdt_cmd_t cmd_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_q <= PDT_CMD_OTHER;
		end else if (vdm_req_acked) begin
			cmd_q <= vdm_req_cmd;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cont_test_exit    <= 1'b0;
			hr_sent_report    <= 1'b0;
			hr_start          <= 1'b0;
			vdm_reply_timeout <= 1'b0;
			vdm_timeout_cmd   <= PDT_CMD_OTHER;
			dpm_notify        <= 1'b0;
			plug_on_timeout   <= 1'b0;
			vdm_answer_late   <= 1'b0;
		end else begin
			cont_test_exit    <= bist_exp;
			hr_sent_report    <= (guard_run && hr_phy_sent) || guard_exp;
			hr_start          <= fault_exp;
			vdm_reply_timeout <= reply_exp;
			if (reply_exp) begin
				vdm_timeout_cmd <= cmd_q;
			end
			dpm_notify        <= entry_exp || leave_exp;
			plug_on_timeout   <= on_exp;
			vdm_answer_late   <= ans_exp;
		end
	end

	// capability advertising gates after a role swap
	always_ff @(posedge clock) begin
		if (rst || clr || swap_src_goodcrc) begin
			caps_send_ok <= 1'b0;
		end else if (hold_exp) begin
			caps_send_ok <= 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (rst || clr || swap_snk_goodcrc) begin
			sink_caps_ready <= 1'b0;
		end else if (rdy_exp) begin
			sink_caps_ready <= 1'b1;
		end
	end

	// source pullup and bus discharge around hard reset
	always_ff @(posedge clock) begin
		if (rst) begin
			pullup_en     <= 1'b0;
			bus_discharge <= 1'b0;
		end else if (sup_exp) begin
			pullup_en     <= 1'b0;
			bus_discharge <= 1'b1;
		end else begin
			pullup_en     <= is_source;
			bus_discharge <= bus_discharge && is_source;
		end
	end

	// plug supply: on by request, off on reset delay or handing the role away
	always_ff @(posedge clock) begin
		if (rst || sup_exp) begin
			plug_supply_en <= 1'b0;
		end else if (plug_ps_rdy_rx && !plug_take_over) begin
			plug_supply_en <= 1'b0;
		end else begin
			plug_supply_en <= plug_supply_on_req;
		end
	end

	assign ps_rdy_tx_ok  = plug_supply_en;
	assign vdm_retry_ok  = !busy_run;
	assign legacy_gap_en = 1'b0;

	// cycles since an unexpected role exchange, held against the fault reset deadline
	localparam int FAULT_MAX = ROLE_FAULT * US_PER_MS * CLK_PER_US + `PDT_OUT_LAT;
	int fault_age_q;
	always_ff @(posedge clock) begin
		if (rst || clr) begin
			fault_age_q <= 0;
		end else if (role_xchg_goodcrc) begin
			fault_age_q <= 1;
		end else if (hr_start) begin
			fault_age_q <= 0;
		end else if (fault_age_q != 0) begin
			fault_age_q <= fault_age_q + 1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_gap_never_on: assert property (!legacy_gap_en)
		else $error("legacy cable gap enabled");
	a_caps_hold_gate: assert property ($rose(caps_send_ok) |-> $past(hold_exp))
		else $error("caps allowed before hold time");
	a_sink_ready_set: assert property (rdy_exp && !clr |=> sink_caps_ready)
		else $error("sink not ready after ready time");
	a_guard_report: assert property (guard_exp |=> hr_sent_report)
		else $error("guard expiry not reported");
	a_supply_drop: assert property (sup_exp |=> !plug_supply_en && !pullup_en &&
		bus_discharge)
		else $error("supply not removed after reset delay");
	a_fault_reset: assert property (fault_age_q <= FAULT_MAX)
		else $error("hard reset not started within fault time");
	a_fault_start: assert property (fault_exp |=> hr_start)
		else $error("hard reset not started");
	a_timeout_cmd: assert property (reply_exp |=> vdm_reply_timeout &&
		vdm_timeout_cmd == $past(cmd_q))
		else $error("timeout carries wrong command");
	a_dpm_notify: assert property (entry_exp || leave_exp |=> dpm_notify)
		else $error("mode timer expiry not notified");
	a_busy_block: assert property (vdm_rsp_rx && vdm_rsp_code == PDT_RSP_BUSY && !clr
		|=> !vdm_retry_ok [*8])
		else $error("retry allowed during backoff");
	a_ps_rdy_gate: assert property (ps_rdy_tx_ok |-> plug_supply_en)
		else $error("PS_RDY allowed with plug supply off");
	a_plug_off: assert property (plug_ps_rdy_rx && !plug_take_over |=>
		!plug_supply_en)
		else $error("initial provider kept plug supply");
	// expiry and confirm events reach their outputs one cycle later
	a_cont_exit: assert property (bist_exp |=> cont_test_exit)
		else $error("continuous test exit not signalled");
	a_answer_late: assert property (ans_exp |=> vdm_answer_late)
		else $error("late answer not flagged");
	a_plug_on_late: assert property (on_exp |=> plug_on_timeout)
		else $error("plug supply on timeout not flagged");
	a_guard_confirm: assert property (guard_run && hr_phy_sent |=> hr_sent_report)
		else $error("confirmed reset signaling not reported");

	c_cont_exit: cover property (cont_test_exit);
	c_caps_open: cover property ($rose(caps_send_ok));
	c_busy_retry: cover property ($rose(vdm_retry_ok));
	c_hr_guard: cover property (guard_exp);
	c_reply_miss: cover property (vdm_reply_timeout);
endmodule

// ==== testbench/pdt_partner_model.sv ====
// port partner model answering our structured vendor requests
module pdt_partner_model
	import pdt_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic [15:0] delay,
	input  wire pdt_rsp_t    code,
	output logic             rsp_rx,
	output pdt_rsp_t         rsp_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] left_q;
	pdt_rsp_t    code_q;
	// a zero delay keeps the partner silent
	always_ff @(posedge clock) begin
		if (rst || go) begin
			left_q <= rst ? 16'h0000 : delay;
			code_q <= code;
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end
	// reply end after the commanded delay; the code wanders outside the pulse
	// plug side at the current revision, so no legacy cable gap precedes a reply
	always_ff @(posedge clock) begin
		rsp_rx   <= !rst && !go && left_q == 16'h0001;
		rsp_code <= (left_q == 16'h0001) ? code_q : pdt_rsp_t'(left_q[1:0] ^ 2'h3);
	end
endmodule

// ==== testbench/tb_pdt_protocol_timers.sv ====
// self-checking bench of the supervision timers
`define CHK(g, e) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
	end \
end
module tb_pdt_protocol_timers
	import pdt_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UPM = 2;
	localparam int CPM = 250 * UPM;
	localparam int LC = 3, LH = 3, LS = 2, LG = 2, LP = 3, LR = 2, LV = 4, LE = 5, LX = 4;
	localparam int LB = 5, LO = 5, LA = 2, LEA = 3, LXA = 3;
	logic        clock, rst, is_source, plug_take_over, plug_supply_on_req, rsp_rx;
	logic        cont_test_exit, caps_send_ok, sink_caps_ready, hr_sent_report, pullup_en;
	logic        bus_discharge, hr_start, vdm_reply_timeout, dpm_notify, vdm_retry_ok;
	logic        vdm_answer_late, plug_supply_en, plug_on_timeout, ps_rdy_tx_ok, legacy_gap_en;
	logic [11:0] ev;
	logic [12:0] o;
	logic [15:0] p_delay;
	pdt_cmd_t    req_cmd, in_cmd, vdm_timeout_cmd;
	pdt_rsp_t    p_code, rsp_code;
	int          cnt [13];
	int          bad_count, check_count, cyc, seed, c0, d;
	assign o = {~plug_supply_en, bus_discharge, plug_on_timeout, vdm_answer_late, vdm_retry_ok,
		dpm_notify, vdm_reply_timeout, hr_start, ~pullup_en, hr_sent_report, sink_caps_ready,
		caps_send_ok, cont_test_exit};
	pdt_protocol_timers #(.US_PER_MS(UPM), .CONT_EXIT(LC), .CAPS_HOLD(LH), .SINK_READY(LS),
		.GUARD(LG), .SUPPLY_RST(LP), .ROLE_FAULT(LR), .REPLY_WAIT(LV), .ENTRY_WAIT(LE),
		.LEAVE_WAIT(LX), .BACKOFF(LB), .PLUG_ON(LO), .ANSWER(LA), .ENTRY_ANS(LEA),
		.LEAVE_ANS(LXA)) unit_under_test (.clock(clock), .rst(rst), .cont_test_goodcrc(ev[0]),
		.cont_test_exit(cont_test_exit), .swap_src_goodcrc(ev[1]), .caps_send_ok(caps_send_ok),
		.swap_snk_goodcrc(ev[2]), .sink_caps_ready(sink_caps_ready), .hr_request(ev[3]),
		.hr_phy_sent(ev[4]), .hr_done(ev[5]), .hr_sent_report(hr_sent_report),
		.is_source(is_source), .pullup_en(pullup_en), .bus_discharge(bus_discharge),
		.role_xchg_goodcrc(ev[6]), .hr_start(hr_start), .vdm_req_acked(ev[7]),
		.vdm_req_cmd(req_cmd), .vdm_rsp_rx(rsp_rx), .vdm_rsp_code(rsp_code),
		.vdm_reply_timeout(vdm_reply_timeout), .vdm_timeout_cmd(vdm_timeout_cmd),
		.dpm_notify(dpm_notify), .vdm_retry_ok(vdm_retry_ok), .vdm_in_req_rx(ev[8]),
		.vdm_in_req_cmd(in_cmd), .vdm_in_rsp_start(ev[9]), .vdm_answer_late(vdm_answer_late),
		.plug_accept_goodcrc(ev[10]), .plug_take_over(plug_take_over),
		.plug_ps_rdy_rx(ev[11]), .plug_supply_on_req(plug_supply_on_req),
		.plug_supply_en(plug_supply_en), .plug_on_timeout(plug_on_timeout),
		.ps_rdy_tx_ok(ps_rdy_tx_ok), .legacy_gap_en(legacy_gap_en));
	pdt_partner_model partner (.clock(clock), .rst(rst), .go(ev[7]), .delay(p_delay),
		.code(p_code), .rsp_rx(rsp_rx), .rsp_code(rsp_code));
	always #2 clock = ~clock;
	always @(posedge clock) begin
		for (int i = 0; i < 13; i++)
			if (o[i] === 1'b1)
				cnt[i]++;
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task fire(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev <= '0;
	endtask
	// waits for an output and checks it came inside the expiry window of l ticks
	task wait_out(input int i, input int l);
		int n;
		n = 0;
		#1;
		while (o[i] !== 1'b1 && n < l * CPM + 6) begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK({o[i], n > (l - 1) * CPM - 8, n <= l * CPM + 5}, 3'h7)
	endtask
	task quiet(input int i, input int c);
		int s;
		@(posedge clock);
		#1;
		s = cnt[i];
		repeat (c) @(posedge clock);
		#1;
		`CHK(cnt[i] - s, 0)
	endtask
	function automatic int ans_limit(input pdt_cmd_t c);
		return (c == PDT_CMD_ENTER) ? LEA : (c == PDT_CMD_EXIT) ? LXA : LA;
	endfunction
	task vdm(input pdt_cmd_t c, input pdt_rsp_t r, input int dl);
		@(posedge clock);
		req_cmd <= c;
		p_code <= r;
		p_delay <= dl[15:0];
		fire(7);
	endtask
	// responder side: answer early by a random delay, or never
	task resp(input pdt_cmd_t c, input bit late);
		int lim;
		lim = ans_limit(c);
		@(posedge clock);
		in_cmd <= c;
		fire(8);
		if (late)
			wait_out(9, lim);
		else begin
			repeat (5 + $unsigned($random(seed)) % 400) @(posedge clock);
			fire(9);
			quiet(9, lim * CPM + 10);
		end
	endtask
	initial begin
		clock = 0;
		rst = 1;
		ev = '0;
		{is_source, plug_take_over, plug_supply_on_req, bad_count, check_count, cyc} = '0;
		req_cmd = PDT_CMD_OTHER;
		in_cmd = PDT_CMD_OTHER;
		p_code = PDT_RSP_ACK;
		p_delay = '0;
		seed = 94825;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		`CHK(o, 13'h1110)
		fire(0); wait_out(0, LC);
		fire(1); wait_out(1, LH);
		fire(2); wait_out(2, LS);
		fire(3); wait_out(3, LG);
		fire(3); fire(4); wait_out(3, 0); quiet(3, LG * CPM);
		fire(6); wait_out(5, LR);
		fire(0); repeat (CPM) @(posedge clock); fire(5); quiet(0, LC * CPM);
		@(posedge clock);
		is_source <= 1'b1;
		fire(5); wait_out(4, LP); `CHK(bus_discharge, 1'b1)
		vdm(PDT_CMD_OTHER, PDT_RSP_ACK, 0); wait_out(6, LV);
		`CHK(vdm_timeout_cmd, PDT_CMD_OTHER)
		vdm(PDT_CMD_ENTER, PDT_RSP_ACK, 0); wait_out(7, LE);
		vdm(PDT_CMD_EXIT, PDT_RSP_NAK, 100); wait_out(7, LX);
		c0 = cnt[6];
		vdm(PDT_CMD_OTHER, PDT_RSP_BUSY, 50);
		repeat (55) @(posedge clock);
		#1;
		`CHK(vdm_retry_ok, 1'b0)
		wait_out(8, LB); `CHK(cnt[6] - c0, 0)
		for (int k = 0; k < 3; k++) begin
			c0 = cnt[6] + cnt[7];
			d = 20 + $unsigned($random(seed)) % 1300;
			vdm(pdt_cmd_t'(k), PDT_RSP_ACK, d);
			repeat (LE * CPM + 10) @(posedge clock);
			`CHK(cnt[6] + cnt[7] - c0, 0)
		end
		for (int k = 0; k < 6; k++)
			resp(pdt_cmd_t'(k % 3), k >= 3);
		@(posedge clock);
		{plug_take_over, plug_supply_on_req} <= 2'h3;
		fire(10);
		repeat (3) @(posedge clock);
		#1;
		`CHK({plug_supply_en, ps_rdy_tx_ok}, 2'h3)
		wait_out(10, LO);
		fire(10); repeat (CPM) @(posedge clock); fire(11); quiet(10, LO * CPM);
		@(posedge clock);
		plug_take_over <= 1'b0;
		fire(11); wait_out(12, 0);
		`CHK(legacy_gap_en, 1'b0)
		fire(0);
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		quiet(0, LC * CPM);
		end_of_test();
	end
endmodule
